// ==== rtl/lmw_pkg.sv ====
/*
  Shared constants and the mode type of the bus transceiver mode and wake controller.
  Assumes a single 250 MHz clock; all times are given in nanoseconds and turned into cycles here.
*/
package lmw_pkg;
  // Clock period in nanoseconds.
  localparam int unsigned CLK_PERIOD_NS = 4;
  // Least high time before a new local wake can be armed, in nanoseconds.
  localparam int unsigned T_REARM_NS = 6000;
  // Least high time that lifts a dominant timeout, in nanoseconds.
  localparam int unsigned DOMINANT_TIMEOUT_RELEASE_NS = 10000;
  // Longest transmit low time before the bus is released, in nanoseconds.
  localparam int unsigned T_DOMINANT_TIMEOUT_NS = 6000000;
  // Debounce times; these are plain defaults, the silicon figures belong to the analog front end.
  localparam int unsigned T_WAKE_NS = 2000;
  localparam int unsigned T_BUS_NS = 2000;
  localparam int unsigned T_NOM_NS = 2000;
  localparam int unsigned T_SLEEP_NS = 2000;
  // Least times round up to whole cycles.
  localparam int unsigned REARM_CYC = (T_REARM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DOM_RELEASE_CYC = (DOMINANT_TIMEOUT_RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DOMINANT_TIMEOUT_CYC =
    (T_DOMINANT_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_CYC = (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUS_CYC = (T_BUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned NOM_CYC = (T_NOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SLEEP_CYC = (T_SLEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Number of pin inputs that pass the two-stage synchroniser.
  localparam int unsigned N_SYNC = 8;
  // Number of debounce filters.
  localparam int unsigned N_FILT = 5;
  // Operating modes, Gray coded along unpowered, fail-safe, normal, sleep.
  typedef enum logic [1:0] {
    LMW_UNPOWERED = 2'h0,
    LMW_FAILSAFE = 2'h1,
    LMW_NORMAL = 2'h3,
    LMW_SLEEP = 2'h2
  } lmw_mode_t;
endpackage : lmw_pkg

// ==== rtl/lmw_filt_if.sv ====
/*
  Carrier between the controller and one debounce filter.
  Assumes both ends share the controller clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface lmw_filt_if;
  logic level; // Qualifying condition seen by the filter.
  logic done;  // High while the condition has held for the filter time.
  modport owner (output level, input done);
  modport timer (input level, output done);
endinterface : lmw_filt_if
`default_nettype wire

// ==== rtl/lmw_filter.sv ====
/*
  Debounce counter: reports once its level has held for CYCLES clocks.
  Assumes the level comes from synchronised logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module lmw_filter #(
  parameter int unsigned CYCLES = 1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  lmw_filt_if.timer f
);
  localparam int unsigned W = $clog2(CYCLES + 1);
  // Refuse a zero filter time, which would report with no qualifying level at all.
  if (CYCLES < 1) begin : g_chk
    $error("lmw_filter CYCLES must be at least one");
  end
  logic [W-1:0] cnt_r;   // Cycles the level has held so far.
  logic [W-1:0] cnt_nxt; // Next count.
  wire at_end = (cnt_r == W'(CYCLES));
  // The count restarts as soon as the level drops and saturates at the end.
  assign cnt_nxt = !f.level ? '0 : (at_end ? cnt_r : cnt_r + 1'b1);
  assign f.done = at_end;
  // Counter register.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule : lmw_filter
`default_nettype wire

// ==== rtl/lmw_domto.sv ====
/*
  Dominant timeout of the transmit input.
  Assumes a synchronised transmit level on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module lmw_domto #(
  parameter int unsigned LOW_CYC = 1,
  parameter int unsigned HIGH_CYC = 1
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic txd_low_i,
  output logic block_o
);
  localparam int unsigned LW = $clog2(LOW_CYC + 1);
  localparam int unsigned HW = $clog2(HIGH_CYC + 1);
  if (LOW_CYC < 1 || HIGH_CYC < 1) begin : g_chk
    $error("lmw_domto counts must be at least one");
  end
  logic [LW-1:0] low_r;  // Cycles the input has been low.
  logic [HW-1:0] high_r; // Cycles the input has been high.
  logic block_r;         // Bus held recessive after a timeout.
  wire low_end = (low_r == LW'(LOW_CYC));
  wire high_end = (high_r == HW'(HIGH_CYC));
  assign block_o = block_r;
  // A long low blocks dominant; only a long enough high lifts the block.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      low_r <= '0;
      high_r <= '0;
      block_r <= 1'b0;
    end else begin
      low_r <= !txd_low_i ? '0 : (low_end ? low_r : low_r + 1'b1);
      high_r <= txd_low_i ? '0 : (high_end ? high_r : high_r + 1'b1);
      if (low_end) begin
        block_r <= 1'b1;
      end else if (high_end) begin
        block_r <= 1'b0;
      end
    end
  end
endmodule : lmw_domto
`default_nettype wire

// ==== rtl/lmw_top.sv ====
/*
  Mode and wake controller of a single-wire bus transceiver: mode sequencing, wake filters,
  wake reporting on the receive and transmit pins, inhibit, termination and driver protection.
  Assumes all pin levels arrive asynchronously and that analog comparators supply the
  supply, pre-wake and temperature levels; open-drain pins are resolved outside.
*/
`timescale 1ns/10ps
`default_nettype none
module lmw_top import lmw_pkg::*; #(
  parameter int unsigned DOMTO_CYC = DOMINANT_TIMEOUT_CYC
) (
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic txd_i,               // Transmit data pin level.
  input wire logic en_i,                // Mode enable pin level.
  input wire logic wake_i,              // Local wake pin level, low requests a wake.
  input wire logic bus_i,               // Bus level, high is recessive.
  input wire logic pre_wake_threshold_i, // High while the bus is below the pre-wake threshold.
  input wire logic battery_supply_ok_i, // High while the supply is above undervoltage.
  input wire logic temp_hot_i,          // High above the shutdown temperature.
  input wire logic temp_cool_i,         // High once cooled by the hysteresis.
  output logic rxd_o,                   // Open-drain receive output value, always low.
  output logic rxd_oe_o,                // Receive output pulled low while high.
  output logic txd_o,                   // Transmit pin drive value, always low.
  output logic txd_oe_o,                // Strong pull-down on the transmit pin.
  output logic txd_weak_pd_o,           // Weak pull-down on the transmit pin.
  output logic en_weak_pd_o,            // Pull-down on the enable pin.
  output logic bus_dominant_o,          // Bus driver on, bus dominant.
  output logic bus_term_o,              // Termination to the supply on.
  output logic bus_weak_pu_o,           // Weak pull-up only, sleep.
  output logic bus_rx_en_o,             // Bus receiver enabled.
  output logic regulator_inhibit_out_o, // Regulator inhibit switch on.
  output lmw_mode_t mode_o              // Present mode.
);
  if (DOMTO_CYC < 1) begin : g_chk
    $error("lmw_top DOMTO_CYC must be at least one");
  end
  // Synchroniser input and stage registers; only stage two is read by logic.
  logic [N_SYNC-1:0] pin_raw;
  logic [N_SYNC-1:0] sync1_r;
  logic [N_SYNC-1:0] sync2_r;
  assign pin_raw = {temp_cool_i, temp_hot_i, battery_supply_ok_i, pre_wake_threshold_i,
                    bus_i, wake_i, en_i, txd_i};
  // Two flip-flops per pin; resetting to low makes open enable and transmit read low.
  for (genvar s = 0; s < N_SYNC; s++) begin : g_sync
    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sync1_r[s] <= 1'b0;
        sync2_r[s] <= 1'b0;
      end else begin
        sync1_r[s] <= pin_raw[s];
        sync2_r[s] <= sync1_r[s];
      end
    end
  end
  wire txd_s = sync2_r[0];
  wire en_s = sync2_r[1];
  wire wake_s = sync2_r[2];
  wire bus_s = sync2_r[3];
  wire prewake_s = sync2_r[4];
  wire supply_s = sync2_r[5];
  wire hot_s = sync2_r[6];
  wire cool_s = sync2_r[7];

  // State.
  lmw_mode_t mode_r;       // Present mode.
  lmw_mode_t mode_nxt;     // Next mode.
  logic en_q_r;            // Debounced enable level.
  logic wake_armed_r;      // Local wake may fire on the next qualified low.
  logic bus_rec_seen_r;    // Recessive seen, so a dominant starts with a falling edge.
  logic bus_dom_seen_r;    // Dominant held for the bus filter time.
  logic wake_req_r;        // Wake request flag shown on the receive output.
  logic wake_local_r;      // Wake source flag, high for a local wake.
  logic therm_off_r;       // Driver off for overtemperature.
  logic dom_block;         // Dominant timeout active.

  // Filters: 0 enable high, 1 enable low, 2 wake low, 3 bus dominant, 4 wake high rearm.
  localparam int unsigned FCYC [N_FILT] = '{NOM_CYC, SLEEP_CYC, WAKE_CYC, BUS_CYC, REARM_CYC};
  logic [N_FILT-1:0] flt_level;
  logic [N_FILT-1:0] flt_done;
  lmw_filt_if fif [N_FILT] ();
  // Each input gets its own filter time.
  assign flt_level = {wake_s, !bus_s && bus_rec_seen_r, !wake_s, !en_s, en_s};
  for (genvar g = 0; g < N_FILT; g++) begin : g_filt
    assign fif[g].level = flt_level[g];
    assign flt_done[g] = fif[g].done;
    lmw_filter #(.CYCLES(FCYC[g])) u_filt (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .f(fif[g])
    );
  end

  // Dominant timeout on the transmit input.
  lmw_domto #(.LOW_CYC(DOMTO_CYC), .HIGH_CYC(DOM_RELEASE_CYC)) u_domto (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .txd_low_i(!txd_s),
    .block_o(dom_block)
  );

  // Decoded events.
  wire in_sleep = (mode_r == LMW_SLEEP);
  wire in_fs = (mode_r == LMW_FAILSAFE);
  wire in_norm = (mode_r == LMW_NORMAL);
  wire en_rise = flt_done[0] && !en_q_r;
  wire en_fall = flt_done[1] && en_q_r;
  // A local wake needs an armed input held low for the filter time.
  wire local_wake = in_sleep && wake_armed_r && flt_done[2];
  // A remote wake completes on the rising edge after a long dominant.
  wire remote_wake = in_sleep && bus_dom_seen_r && bus_s;
  wire any_wake = local_wake || remote_wake;
  // Sleep follows an enable fall with transmit high, whatever bus and wake do.
  wire go_sleep = (in_norm || in_fs) && en_fall && txd_s;

  // Mode sequencing.
  always_comb begin
    mode_nxt = mode_r;
    case (mode_r)
      LMW_UNPOWERED: begin
        // Supply above undervoltage lands in fail-safe.
        if (supply_s) begin
          mode_nxt = LMW_FAILSAFE;
        end
      end
      LMW_FAILSAFE: begin
        if (go_sleep) begin
          mode_nxt = LMW_SLEEP;
        end else if (en_rise) begin
          mode_nxt = LMW_NORMAL;
        end
      end
      LMW_NORMAL: begin
        if (go_sleep) begin
          mode_nxt = LMW_SLEEP;
        end
      end
      LMW_SLEEP: begin
        // Only a wake or undervoltage leaves sleep; a held wake low without rearm keeps it here.
        if (any_wake) begin
          mode_nxt = LMW_FAILSAFE;
        end
      end
      default: begin
        mode_nxt = LMW_UNPOWERED;
      end
    endcase
    // Undervoltage overrides every mode and stops transmission.
    if (!supply_s) begin
      mode_nxt = LMW_UNPOWERED;
    end
  end

  // Mode register and debounced enable level.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_r <= LMW_UNPOWERED;
      en_q_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      en_q_r <= en_rise ? 1'b1 : (en_fall ? 1'b0 : en_q_r);
    end
  end

  // Local wake arming: a long high arms, a fired wake disarms.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_armed_r <= 1'b0;
    end else if (flt_done[4]) begin
      wake_armed_r <= 1'b1;
    end else if (local_wake) begin
      wake_armed_r <= 1'b0;
    end
  end

  // Remote wake tracking, only while asleep.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_rec_seen_r <= 1'b0;
      bus_dom_seen_r <= 1'b0;
    end else if (!in_sleep || remote_wake) begin
      bus_rec_seen_r <= 1'b0;
      bus_dom_seen_r <= 1'b0;
    end else begin
      bus_rec_seen_r <= bus_rec_seen_r || bus_s;
      bus_dom_seen_r <= bus_dom_seen_r || flt_done[3];
    end
  end

  // Wake flags: a wake sets them, synchronised enable high clears them, set wins.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wake_req_r <= 1'b0;
      wake_local_r <= 1'b0;
    end else if (any_wake) begin
      wake_req_r <= 1'b1;
      wake_local_r <= local_wake;
    end else if (en_s || !supply_s) begin
      wake_req_r <= 1'b0;
      wake_local_r <= 1'b0;
    end
  end

  // Thermal shutdown latch with hysteresis; a hot level wins over cool.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      therm_off_r <= 1'b0;
    end else if (hot_s) begin
      therm_off_r <= 1'b1;
    end else if (cool_s) begin
      therm_off_r <= 1'b0;
    end
  end

  // Output decode.
  wire powered = (mode_r != LMW_UNPOWERED);
  // Normal drives the bus from transmit data unless protected.
  wire dom_nxt = in_norm && !txd_s && !therm_off_r && !dom_block;
  // Receive output: bus in normal, wake flag in fail-safe, floating otherwise.
  wire rxd_nxt = (in_norm && !bus_s) || (in_fs && wake_req_r);
  // Strong pull-down marks a local wake; weak pull-down is on whenever powered.
  wire txd_nxt = in_fs && wake_req_r && wake_local_r;
  // Termination on when awake or below pre-wake; sleep keeps weak pull-up.
  wire term_nxt = in_fs || in_norm || (in_sleep && prewake_s);
  // Receiver on in normal, in fail-safe with transmit low, and below pre-wake.
  wire rxen_nxt = in_norm || (in_fs && !txd_s) || (powered && prewake_s);
  // Inhibit on when awake, off in sleep.
  wire inh_nxt = in_fs || in_norm;

  // Output registers.
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_dominant_o <= 1'b0;
      rxd_oe_o <= 1'b0;
      txd_oe_o <= 1'b0;
      bus_term_o <= 1'b0;
      bus_weak_pu_o <= 1'b0;
      bus_rx_en_o <= 1'b0;
      regulator_inhibit_out_o <= 1'b0;
      txd_weak_pd_o <= 1'b0;
      en_weak_pd_o <= 1'b0;
    end else begin
      bus_dominant_o <= dom_nxt;
      rxd_oe_o <= rxd_nxt;
      txd_oe_o <= txd_nxt;
      bus_term_o <= term_nxt;
      bus_weak_pu_o <= in_sleep && !prewake_s;
      bus_rx_en_o <= rxen_nxt;
      regulator_inhibit_out_o <= inh_nxt;
      txd_weak_pd_o <= powered;
      en_weak_pd_o <= powered;
    end
  end
  assign rxd_o = 1'b0;
  assign txd_o = 1'b0;
  assign mode_o = mode_r;

  // Checks.
  AST_NORMAL_TX: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    bus_dominant_o |-> $past(in_norm) && !$past(txd_s)) else $error("dominant outside normal");
  AST_SLEEP_NO_TX: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(in_sleep) |-> !bus_dominant_o) else $error("dominant in sleep");
  AST_SLEEP_INH: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    $past(in_sleep) |-> !regulator_inhibit_out_o) else $error("inhibit on in sleep");
  AST_FS_TO_NORM: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    in_fs && en_rise && !go_sleep && supply_s |=> in_norm) else $error("no normal");
  AST_WAKE_FS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    any_wake && supply_s |=> in_fs ##1 regulator_inhibit_out_o) else $error("wake not fs");
  AST_LOCAL_SRC: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    local_wake && supply_s |=> ##1 (txd_oe_o && rxd_oe_o) || en_s) else $error("local src");
  AST_REMOTE_SRC: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    remote_wake && !local_wake |=> ##1 !txd_oe_o) else $error("remote wake shows local");
  AST_FLAG_CLR: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    en_s && !any_wake |=> !wake_req_r) else $error("wake flag not cleared");
  AST_UV: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    !supply_s |=> mode_r == LMW_UNPOWERED ##1 !bus_dominant_o) else $error("undervoltage");
  AST_SLEEP_ENTRY: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    go_sleep && supply_s |=> in_sleep) else $error("sleep entry missed");
  AST_THERM: assert property (@(posedge clock_i) disable iff (!rst_b_i)
    hot_s |=> ##1 !bus_dominant_o) else $error("driver on while hot");
  COV_LOCAL: cover property (@(posedge clock_i) disable iff (!rst_b_i) local_wake);
  COV_REMOTE: cover property (@(posedge clock_i) disable iff (!rst_b_i) remote_wake);
  COV_NORMAL: cover property (@(posedge clock_i) disable iff (!rst_b_i) in_fs ##1 in_norm);
  COV_DOMTO: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(dom_block));
endmodule : lmw_top
`default_nettype wire

// ==== sim/lmw_far_model.sv ====
/*
  Far-side model: the controller's transmit pin and the other bus nodes.
  Assumes an external pull-up on the transmit and receive pins and on the bus.
*/
`timescale 1ns/10ps
`default_nettype none
module lmw_far_model (
  input wire logic ctrl_txd_i,   // Value the controller drives on the transmit pin.
  input wire logic ctrl_txd_oe_i, // High while the controller drives the transmit pin.
  input wire logic dut_txd_pd_i, // Strong pull-down of the device.
  input wire logic dut_bus_dom_i, // Device bus driver on.
  input wire logic remote_dom_i, // Another node pulls the bus dominant.
  input wire logic dut_rxd_pd_i, // Device pulls the receive pin low.
  output logic txd_o,            // Resolved transmit pin level.
  output logic bus_o,            // Resolved bus level, high is recessive.
  output logic below_pre_wake_o, // Bus below the pre-wake threshold.
  output logic rxd_o             // Resolved receive pin level.
);
  // The strong pull-down wins; a weak pull-down loses to the pull-up.
  assign txd_o = dut_txd_pd_i ? 1'b0 : (ctrl_txd_oe_i ? ctrl_txd_i : 1'b1);
  // Wired-and bus: any node pulling makes it dominant.
  assign bus_o = ~(dut_bus_dom_i | remote_dom_i);
  // A dominant bus sits far below the pre-wake threshold.
  assign below_pre_wake_o = ~bus_o;
  // Open drain with a pull-up: released reads high.
  assign rxd_o = ~dut_rxd_pd_i;
endmodule : lmw_far_model
`default_nettype wire

// ==== sim/tb.sv ====
/*
  Self-checking bench of the mode and wake controller.
  Assumes the far-side model resolves the pins; inputs change on the falling edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tb import lmw_pkg::*;;
  logic clock_i, rst_b_i, en_i, wake_i, supply_ok, hot, cool;
  logic ctrl_txd, ctrl_oe, remote_dom, txd_pin, bus, pre_wake, rxd_pin;
  logic rxd_oe, txd_oe, bus_dom, term, weak_pu, regulator_inhibit_out;
  logic rx_en, txd_wpd, en_wpd, rxd_val, txd_val;
  lmw_mode_t mode;
  int error_cnt = 0;
  int tests_run = 0;
  // Short timeout keeps the run brief.
  localparam int unsigned DOMTO = 50;
  lmw_top #(.DOMTO_CYC(DOMTO)) dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .txd_i(txd_pin),
    .en_i(en_i), .wake_i(wake_i), .bus_i(bus), .pre_wake_threshold_i(pre_wake),
    .battery_supply_ok_i(supply_ok), .temp_hot_i(hot), .temp_cool_i(cool), .rxd_o(rxd_val),
    .rxd_oe_o(rxd_oe), .txd_o(txd_val), .txd_oe_o(txd_oe), .txd_weak_pd_o(txd_wpd),
    .en_weak_pd_o(en_wpd),
    .bus_dominant_o(bus_dom), .bus_term_o(term), .bus_weak_pu_o(weak_pu), .bus_rx_en_o(rx_en),
    .regulator_inhibit_out_o(regulator_inhibit_out), .mode_o(mode));
  lmw_far_model far (.ctrl_txd_i(ctrl_txd), .ctrl_txd_oe_i(ctrl_oe), .dut_txd_pd_i(txd_oe),
    .dut_bus_dom_i(bus_dom), .remote_dom_i(remote_dom), .dut_rxd_pd_i(rxd_oe),
    .txd_o(txd_pin), .bus_o(bus), .below_pre_wake_o(pre_wake), .rxd_o(rxd_pin));
  // Free-running clock of 4 ns.
  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end
  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : conclude
  // Compares one seen value with its expectation.
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %0h want %0h", $time, seen, exp);
    end
  endtask : check
  // Waits whole cycles, ending on a falling edge.
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask : cyc
  // Bounded wait for a mode; running out counts as a mismatch.
  task automatic wait_mode(input logic [1:0] m, input int bound);
    for (int i = 0; i < bound; i++) begin
      if (mode === m) begin
        cyc(3);
        return;
      end
      cyc(1);
    end
    error_cnt++;
    $display("unexpected at %0t: mode wait ran out", $time);
    conclude();
  endtask : wait_mode
  // Supply good brings fail-safe with inhibit on and no transmission.
  task automatic power_up();
    ctrl_oe = 1'b0;
    supply_ok = 1'b1;
    wait_mode(LMW_FAILSAFE, 20);
    check(regulator_inhibit_out, 1'b1);
    check(bus_dom, 1'b0);
    check(rxd_pin, 1'b1);
    check(rx_en, 1'b0);
    check({txd_val, rxd_val}, 2'h0);
    check({txd_wpd, en_wpd}, 2'h3);
    // A short transmit low in fail-safe wakes the receiver but never the driver.
    ctrl_oe = 1'b1;
    ctrl_txd = 1'b0;
    cyc(6);
    check(rx_en, 1'b1);
    check(bus_dom, 1'b0);
    ctrl_txd = 1'b1;
    cyc(6);
    check(rx_en, 1'b0);
  endtask : power_up
  // Enable high confirms normal; both paths then work.
  task automatic go_normal();
    en_i = 1'b1;
    ctrl_oe = 1'b1;
    ctrl_txd = 1'b1;
    wait_mode(LMW_NORMAL, 1000);
    check(regulator_inhibit_out, 1'b1);
    check(rx_en, 1'b1);
    ctrl_txd = 1'b0;
    cyc(6);
    check(bus_dom, 1'b1);
    check(rxd_pin, 1'b0);
    ctrl_txd = 1'b1;
    cyc(6);
    check(bus_dom, 1'b0);
    check(rxd_pin, 1'b1);
  endtask : go_normal
  // Overtemperature drops the driver until cooled.
  task automatic thermal();
    hot = 1'b1;
    cyc(4);
    ctrl_txd = 1'b0;
    cyc(6);
    check(bus_dom, 1'b0);
    hot = 1'b0;
    cool = 1'b1;
    cyc(6);
    check(bus_dom, 1'b1);
    ctrl_txd = 1'b1;
    cool = 1'b0;
    cyc(6);
  endtask : thermal
  // A stuck low transmit releases the bus until a long high.
  task automatic dom_timeout();
    ctrl_txd = 1'b0;
    cyc(DOMTO + 20);
    check(bus_dom, 1'b0);
    ctrl_txd = 1'b1;
    cyc(2600);
    ctrl_txd = 1'b0;
    cyc(6);
    check(bus_dom, 1'b1);
    ctrl_txd = 1'b1;
    cyc(6);
  endtask : dom_timeout
  // Enable fall with transmit high enters sleep.
  task automatic go_sleep();
    ctrl_txd = 1'b1;
    en_i = 1'b0;
    wait_mode(LMW_SLEEP, 1000);
    ctrl_oe = 1'b0;
    check(regulator_inhibit_out, 1'b0);
    check(term, 1'b0);
    check(weak_pu, 1'b1);
    check(rxd_pin, 1'b1);
  endtask : go_sleep
  // Bus wake: short dominant ignored, long dominant then release wakes.
  task automatic remote_wake();
    remote_dom = 1'b1;
    cyc(100);
    remote_dom = 1'b0;
    cyc(20);
    check(mode, LMW_SLEEP);
    remote_dom = 1'b1;
    cyc(600);
    check(bus_dom, 1'b0);
    check({rx_en, term}, 2'h3);
    remote_dom = 1'b0;
    wait_mode(LMW_FAILSAFE, 20);
    check(regulator_inhibit_out, 1'b1);
    check(term, 1'b1);
    check(rxd_pin, 1'b0);
    check(txd_pin, 1'b1);
    en_i = 1'b1;
    cyc(6);
    check(rxd_pin, 1'b1);
    ctrl_oe = 1'b1;
    wait_mode(LMW_NORMAL, 1000);
  endtask : remote_wake
  // Switch wake, then sleep while the switch stays low.
  task automatic local_wake();
    wake_i = 1'b0;
    cyc(100);
    wake_i = 1'b1;
    cyc(1600);
    check(mode, LMW_SLEEP);
    wake_i = 1'b0;
    wait_mode(LMW_FAILSAFE, 1000);
    check(txd_pin, 1'b0);
    check(rxd_pin, 1'b0);
    check(term, 1'b1);
    en_i = 1'b1;
    cyc(6);
    check(txd_oe, 1'b0);
    ctrl_oe = 1'b1;
    wait_mode(LMW_NORMAL, 1000);
    go_sleep();
    cyc(700);
    check(mode, LMW_SLEEP);
    // A high shorter than the rearm time must not arm a new wake.
    wake_i = 1'b1;
    cyc(1000);
    wake_i = 1'b0;
    cyc(700);
    check(mode, LMW_SLEEP);
    wake_i = 1'b1;
    cyc(1600);
    wake_i = 1'b0;
    wait_mode(LMW_FAILSAFE, 1000);
    check(rxd_pin, 1'b0);
  endtask : local_wake
  // Losing the supply stops transmission and floats the receive pin.
  task automatic brown_out();
    supply_ok = 1'b0;
    wait_mode(LMW_UNPOWERED, 20);
    check(rxd_pin, 1'b1);
    check(bus_dom, 1'b0);
    check({txd_wpd, en_wpd}, 2'h0);
  endtask : brown_out
  // Main sequence through every mode.
  initial begin
    {rst_b_i, en_i, supply_ok, hot, cool, ctrl_txd, ctrl_oe, remote_dom} = 8'h00;
    wake_i = 1'b1;
    cyc(4);
    rst_b_i = 1'b1;
    cyc(2);
    power_up();
    go_normal();
    thermal();
    dom_timeout();
    go_sleep();
    remote_wake();
    go_sleep();
    local_wake();
    brown_out();
    conclude();
  end
endmodule : tb
`default_nettype wire
